// ===== verilog/asfr_pkg.sv
package asfr_pkg;
   localparam logic [15:0] SYNC_WORD = 16'h0b77;
   localparam int CLK_MHZ = 100;
   localparam int BLOCKS_PER_FRAME = 6;
   localparam int SAMPLES_PER_FRAME = 1536;
   localparam int FRAME_MS = 32;
   localparam int BLOCK_US = 5300;
   localparam int FADE_US = 2600;
   localparam int FADE_CYC = FADE_US * CLK_MHZ;
   localparam logic [1:0] FS_48K = 2'h0;
   localparam int REMAT_BANDS = 4;
   localparam int MANT_MAX_BITS = 16;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [15:0] GAIN_FULL = 16'hffff;
   typedef enum logic [2:0] {
      ASFR_SEARCH = 3'h1,
      ASFR_HEADER = 3'h2,
      ASFR_BODY = 3'h4
   } asfr_state_t;
   function automatic logic [15:0] asfr_crc_step(input logic [15:0] c, input logic b);
      asfr_crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
   endfunction : asfr_crc_step
endpackage : asfr_pkg

// ===== verilog/asfr_receiver.sv
`timescale 1ns/100ps
// Contract
// - Stream is fixed-size frames: sync, stream info, six blocks of 5.3 ms, check code.
// - Extract 16-bit sync word, sample-rate code (48 kHz) and frame-size code.
// - Check the trailing 16-bit code to judge each frame damaged or incomplete.
// - A frame failing the check mutes the output.
// - Missing sync where the next frame starts drops lock into sync search.
// - Finding sync in search regains lock and lets audio resume; lock returns after the header, unmute waits for a frame passing the check.
// - Mute fades down over about 2.6 ms; recovery fades up over 2.6 ms.
// - Transport error flags are combined with the own check result.
// - On any frame error the output is muted, no concealment.
// - Coupling active implies coordinates present in block 0.
// - New coupling coordinates accepted in any later block, else previous kept.
// - Mantissa precision from 0 to 16 bits per mantissa is supported; the code gives 0 or 2 to 16 bits, never 1.
// - Bit allocation pointer selects the quantizer for each mantissa.
// - Stereo mode: four rematrix flags, left/right or sum/difference per band.
// - Each complete frame stands for 1536 samples, decoded independently.
module asfr_receiver
   import asfr_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic bit_valid_i,
   input wire logic bit_i,
   input wire logic transport_err_i,
   input wire logic [15:0] frame_bits_i,
   input wire logic [2:0] block_idx_i,
   input wire logic block_start_i,
   input wire logic cpl_active_i,
   input wire logic cpl_coord_valid_i,
   input wire logic [7:0] cpl_coord_i,
   input wire logic stereo_mode_i,
   input wire logic [3:0] remat_flags_i,
   input wire logic [3:0] bap_i,
   output logic locked_o,
   output logic frame_ok_o,
   output logic frame_err_o,
   output logic [1:0] sample_rate_o,
   output logic [5:0] frame_size_o,
   output logic [15:0] gain_o,
   output logic [7:0] cpl_coord_o,
   output logic cpl_missing_o,
   output logic [3:0] remat_o,
   output logic [4:0] mant_bits_o
);
   asfr_state_t state_reg, state_next;
   logic [15:0] shift_reg, shift_next;
   logic [15:0] crc_reg, crc_next;
   logic [15:0] cnt_reg, cnt_next;
   logic terr_reg, terr_next;
   logic locked_reg, locked_next;
   logic ok_reg, ok_next;
   logic err_reg, err_next;
   logic [1:0] fs_reg, fs_next;
   logic [5:0] fsz_reg, fsz_next;
   logic mute_reg, mute_next;
   logic [15:0] gain_reg, gain_next;
   logic [15:0] fade_reg, fade_next;
   logic [7:0] coord_reg, coord_next;
   logic miss_reg, miss_next;
   logic [3:0] remat_reg, remat_next;
   logic [4:0] mant_reg, mant_next;
   logic [15:0] sh;
   logic [31:0] step;
   logic [31:0] ramp;
   logic [31:0] ramp_next;

   // Frame framing: sync hunt, header capture, body with running check code.
   always_comb begin
      sh = {shift_reg[14:0], bit_i};
      state_next = state_reg;
      shift_next = shift_reg;
      crc_next = crc_reg;
      cnt_next = cnt_reg;
      terr_next = terr_reg | transport_err_i;
      locked_next = locked_reg;
      ok_next = 1'b0;
      err_next = 1'b0;
      fs_next = fs_reg;
      fsz_next = fsz_reg;
      if (bit_valid_i) begin
         shift_next = sh;
         case (state_reg)
            ASFR_SEARCH: begin
               // One bit position per valid bit.
               if (sh == SYNC_WORD) begin
                  state_next = ASFR_HEADER;
                  cnt_next = 16'h0000;
                  crc_next = CRC_INIT;
                  terr_next = transport_err_i;
               end
            end
            ASFR_HEADER: begin
               crc_next = asfr_crc_step(crc_reg, bit_i);
               cnt_next = cnt_reg + 16'h0001;
               if (cnt_reg == 16'h0007) begin
                  fs_next = sh[7:6];
                  fsz_next = sh[5:0];
                  state_next = ASFR_BODY;
                  locked_next = 1'b1;
               end
            end
            ASFR_BODY: begin
               crc_next = asfr_crc_step(crc_reg, bit_i);
               cnt_next = cnt_reg + 16'h0001;
               if (cnt_reg == frame_bits_i - 16'h0011) begin
                  // Frame end; CRC over header, body and check field.
                  ok_next = (asfr_crc_step(crc_reg, bit_i) == 16'h0000) && !terr_reg;
                  err_next = !ok_next;
                  state_next = ASFR_SEARCH;
               end
            end
            default: state_next = ASFR_SEARCH;
         endcase
         // A fresh frame must begin with sync straight after the last one.
         // Only valid bits count, zero bits included; a stream that stops sending bits keeps lock.
         if (state_reg == ASFR_SEARCH && locked_reg) begin
            cnt_next = (sh == SYNC_WORD) ? 16'h0000 : cnt_reg + 16'h0001;
            if (sh != SYNC_WORD && cnt_reg >= 16'h000f) begin
               locked_next = 1'b0;
            end
         end
         if (state_reg == ASFR_BODY && cnt_reg == frame_bits_i - 16'h0011) begin
            cnt_next = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ASFR_SEARCH;
         shift_reg <= 16'h0000;
         crc_reg <= CRC_INIT;
         cnt_reg <= 16'h0000;
         terr_reg <= 1'b0;
         locked_reg <= 1'b0;
         ok_reg <= 1'b0;
         err_reg <= 1'b0;
         fs_reg <= FS_48K;
         fsz_reg <= 6'h00;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         crc_reg <= crc_next;
         cnt_reg <= cnt_next;
         terr_reg <= terr_next;
         locked_reg <= locked_next;
         ok_reg <= ok_next;
         err_reg <= err_next;
         fs_reg <= fs_next;
         fsz_reg <= fsz_next;
      end
   end

   // Mute and linear fade; errors always mute rather than conceal.
   // The gain ramps as a 32-bit value: gain_reg is its upper half and fade_reg the fraction.
   // A whole swing thus takes about FADE_CYC cycles rather than only 64k.
   always_comb begin
      step = 32'((64'(GAIN_FULL) << 16) / 64'(FADE_CYC) + 64'h1);
      mute_next = mute_reg;
      if (err_reg || !locked_reg) begin
         mute_next = 1'b1;
      end else if (ok_reg) begin
         mute_next = 1'b0;
      end
      if (mute_reg) begin
         ramp_next = (ramp > step) ? ramp - step : 32'h0000_0000;
      end else begin
         ramp_next = (32'hffff_ffff - ramp > step) ? ramp + step : 32'hffff_ffff;
      end
      gain_next = ramp_next[31:16];
      fade_next = ramp_next[15:0];
   end

   // Block side information.
   always_comb begin
      coord_next = coord_reg;
      miss_next = 1'b0;
      remat_next = remat_reg;
      if (block_start_i && cpl_active_i) begin
         if (cpl_coord_valid_i) begin
            coord_next = cpl_coord_i;
         end else if (block_idx_i == 3'h0) begin
            miss_next = 1'b1;
         end
      end
      if (block_start_i && stereo_mode_i) begin
         remat_next = remat_flags_i;
      end
      // Quantizer word length is the allocation pointer plus one, at most 16; pointer 0 gives 0.
      mant_next = (bap_i == 4'h0) ? 5'h00 : 5'(bap_i) + 5'h01;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mute_reg <= 1'b1;
         gain_reg <= 16'h0000;
         fade_reg <= 16'h0000;
         coord_reg <= 8'h00;
         miss_reg <= 1'b0;
         remat_reg <= 4'h0;
         mant_reg <= 5'h00;
      end else begin
         mute_reg <= mute_next;
         gain_reg <= gain_next;
         fade_reg <= fade_next;
         coord_reg <= coord_next;
         miss_reg <= miss_next;
         remat_reg <= remat_next;
         mant_reg <= mant_next;
      end
   end

   assign locked_o = locked_reg;
   assign frame_ok_o = ok_reg;
   assign frame_err_o = err_reg;
   assign sample_rate_o = fs_reg;
   assign frame_size_o = fsz_reg;
   assign gain_o = gain_reg;
   assign cpl_coord_o = coord_reg;
   assign cpl_missing_o = miss_reg;
   assign remat_o = remat_reg;
   assign mant_bits_o = mant_reg;
   assign ramp = {gain_reg, fade_reg};

   property p_err_mutes;
      @(posedge clk_i) disable iff (!arst_n_i) err_reg |=> mute_reg;
   endproperty
   a_err_mutes: assert property (p_err_mutes) else $error("error did not mute");
   property p_conceal_none;
      @(posedge clk_i) disable iff (!arst_n_i)
         (err_reg && !ok_reg) |=> ##1 (ramp < $past(ramp) || ramp == 32'h0000_0000);
   endproperty
   a_conceal_none: assert property (p_conceal_none) else $error("gain not falling");
   property p_fade_down;
      @(posedge clk_i) disable iff (!arst_n_i)
         (mute_reg && ramp != 32'h0000_0000) |=> ramp < $past(ramp);
   endproperty
   a_fade_down: assert property (p_fade_down) else $error("fade down stalled");
   property p_fade_up;
      @(posedge clk_i) disable iff (!arst_n_i)
         (!mute_reg && ramp != 32'hffff_ffff) |=> ramp > $past(ramp);
   endproperty
   a_fade_up: assert property (p_fade_up) else $error("fade up stalled");
   property p_unlock;
      @(posedge clk_i) disable iff (!arst_n_i)
         (locked_reg && state_reg == ASFR_SEARCH && bit_valid_i && cnt_reg >= 16'h000f
          && {shift_reg[14:0], bit_i} != SYNC_WORD) |=> !locked_reg;
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock kept without sync");
   property p_hunt;
      @(posedge clk_i) disable iff (!arst_n_i)
         (state_reg == ASFR_SEARCH && bit_valid_i && {shift_reg[14:0], bit_i} == SYNC_WORD)
         |=> state_reg == ASFR_HEADER;
   endproperty
   a_hunt: assert property (p_hunt) else $error("sync seen but not taken");
   property p_relock;
      @(posedge clk_i) disable iff (!arst_n_i)
         $rose(locked_reg) |-> $past(state_reg) == ASFR_HEADER;
   endproperty
   a_relock: assert property (p_relock) else $error("lock outside header");
   property p_frame_end;
      @(posedge clk_i) disable iff (!arst_n_i)
         (ok_reg || err_reg) |-> $past(state_reg) == ASFR_BODY && state_reg == ASFR_SEARCH;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("verdict off frame end");
   property p_hdr;
      @(posedge clk_i) disable iff (!arst_n_i)
         (state_reg == ASFR_HEADER && bit_valid_i && cnt_reg == 16'h0007)
         |=> fs_reg == $past(shift_reg[6:5]) && fsz_reg == $past({shift_reg[4:0], bit_i});
   endproperty
   a_hdr: assert property (p_hdr) else $error("header fields not taken");
   property p_quant;
      @(posedge clk_i) disable iff (!arst_n_i)
         (bap_i != 4'h0) |=> mant_reg == 5'($past(bap_i)) + 5'h01;
   endproperty
   a_quant: assert property (p_quant) else $error("wrong quantizer width");
   property p_okerr;
      @(posedge clk_i) disable iff (!arst_n_i) !(ok_reg && err_reg);
   endproperty
   a_okerr: assert property (p_okerr) else $error("ok and error together");
   property p_terr;
      @(posedge clk_i) disable iff (!arst_n_i) ok_reg |-> !$past(terr_reg);
   endproperty
   a_terr: assert property (p_terr) else $error("transport error ignored");
   property p_coord;
      @(posedge clk_i) disable iff (!arst_n_i)
         (block_start_i && cpl_active_i && cpl_coord_valid_i) |=> coord_reg == $past(cpl_coord_i);
   endproperty
   a_coord: assert property (p_coord) else $error("coordinates not taken");
   property p_miss;
      @(posedge clk_i) disable iff (!arst_n_i)
         (block_start_i && cpl_active_i && !cpl_coord_valid_i && block_idx_i == 3'h0) |=> miss_reg;
   endproperty
   a_miss: assert property (p_miss) else $error("missing block0 coordinates");
   property p_mant;
      @(posedge clk_i) disable iff (!arst_n_i) mant_reg <= 5'(MANT_MAX_BITS);
   endproperty
   a_mant: assert property (p_mant) else $error("mantissa too wide");
   property p_remat;
      @(posedge clk_i) disable iff (!arst_n_i) (block_start_i && stereo_mode_i) |=> remat_reg == $past(remat_flags_i);
   endproperty
   a_remat: assert property (p_remat) else $error("rematrix flags lost");
   c_lock: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(locked_reg));
   c_ok: cover property (@(posedge clk_i) disable iff (!arst_n_i) ok_reg);
   c_err: cover property (@(posedge clk_i) disable iff (!arst_n_i) err_reg);
   c_unlock: cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(locked_reg));
   c_miss: cover property (@(posedge clk_i) disable iff (!arst_n_i) miss_reg);
endmodule : asfr_receiver

// ===== testbench/asfr_demux_model.sv
`timescale 1ns/100ps
module asfr_demux_model
   import asfr_pkg::*;
(
   input wire logic clk_i,
   output logic bit_valid_o,
   output logic bit_o,
   output logic transport_err_o
);
   initial begin
      bit_valid_o = 1'b0;
      bit_o = 1'b0;
      transport_err_o = 1'b0;
   end
   // Builds sync, header, body and a check code that leaves a zero remainder.
   function automatic logic [63:0] frame(input logic [15:0] sync, input logic [7:0] hdr,
                                         input logic [23:0] body);
      logic [31:0] d;
      logic [15:0] c;
      d = {hdr, body};
      c = CRC_INIT;
      for (int i = 31; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      end
      frame = {sync, d, c};
   endfunction : frame
   // Sends v[n-1:0] first bit first; the error flag is raised with bit err_at.
   task automatic send(input logic [127:0] v, input int n, input int err_at);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_i);
         #1;
         bit_valid_o = 1'b1;
         bit_o = v[i];
         transport_err_o = (i == err_at);
      end
      @(posedge clk_i);
      #1;
      bit_valid_o = 1'b0;
      bit_o = ~bit_o;
      transport_err_o = 1'b0;
   endtask : send
endmodule : asfr_demux_model

// ===== testbench/asfr_receiver_bench.sv
`timescale 1ns/100ps
module asfr_receiver_bench;
   import asfr_pkg::*;
   logic clk_i, arst_n_i, bv, bt, terr, bstart, cact, cval, stereo, locked, f_ok, f_err, cmiss;
   logic [2:0] bidx;
   logic [7:0] ccoord, coord_o;
   logic [3:0] remat, bap, remat_o;
   logic [1:0] rate;
   logic [5:0] fsize;
   logic [15:0] gain, g;
   logic [4:0] mbits;
   logic [63:0] good;
   int error_cnt = 0;
   int n_checks = 0;
   int ok_cnt = 0;
   int err_cnt_f = 0;
   int b0, e0;
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   asfr_demux_model dmx (.clk_i(clk_i), .bit_valid_o(bv), .bit_o(bt), .transport_err_o(terr));
   asfr_receiver uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .bit_valid_i(bv), .bit_i(bt),
      .transport_err_i(terr), .frame_bits_i(16'h0040), .block_idx_i(bidx),
      .block_start_i(bstart), .cpl_active_i(cact), .cpl_coord_valid_i(cval),
      .cpl_coord_i(ccoord), .stereo_mode_i(stereo), .remat_flags_i(remat), .bap_i(bap),
      .locked_o(locked), .frame_ok_o(f_ok), .frame_err_o(f_err), .sample_rate_o(rate),
      .frame_size_o(fsize), .gain_o(gain), .cpl_coord_o(coord_o), .cpl_missing_o(cmiss),
      .remat_o(remat_o), .mant_bits_o(mbits));
   always @(posedge clk_i) begin
      if (f_ok === 1'b1) ok_cnt++;
      if (f_err === 1'b1) err_cnt_f++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   // Sends n bits, then lets the end-of-frame pulse land.
   task automatic xfer(input logic [127:0] v, input int n, input int err_at);
      b0 = ok_cnt;
      e0 = err_cnt_f;
      dmx.send(v, n, err_at);
      repeat (4) @(posedge clk_i);
      #1;
   endtask : xfer
   task automatic t_lock();
      xfer({64'h0, good}, 64, -1);
      check(locked, 1'b1);
      check(ok_cnt - b0, 1);
      check(rate, FS_48K);
      check(fsize, 6'h2a);
      repeat (400) @(posedge clk_i);
      check(gain > 16'h0000 && gain < 16'(500 * int'(GAIN_FULL) / FADE_CYC), 1'b1);
   endtask : t_lock
   task automatic t_b2b();
      xfer({good, good}, 128, -1);
      check(ok_cnt - b0, 2);
      check(err_cnt_f - e0, 0);
      check(locked, 1'b1);
   endtask : t_b2b
   task automatic t_crc_err();
      g = gain;
      xfer({64'h0, good ^ 64'h100000}, 64, -1);
      check(err_cnt_f - e0, 1);
      check(ok_cnt - b0, 0);
      repeat (400) @(posedge clk_i);
      check(gain < g, 1'b1);
      xfer({64'h0, good}, 64, 30);
      check(err_cnt_f - e0, 1);
      check(ok_cnt - b0, 0);
   endtask : t_crc_err
   task automatic t_loss();
      xfer({64'h0, dmx.frame(16'h0b76, 8'h2a, 24'h5a3c96)}, 64, -1);
      check(locked, 1'b0);
      g = gain;
      xfer({61'h0, good, 3'h5}, 67, -1);
      check(locked, 1'b1);
      check(ok_cnt - b0, 1);
      repeat (400) @(posedge clk_i);
      check(gain > g, 1'b1);
   endtask : t_loss
   task automatic blk(input logic [2:0] idx, input logic v, input logic [7:0] c,
                      input logic [3:0] b);
      @(posedge clk_i);
      #1;
      bidx = idx;
      cval = v;
      ccoord = c;
      bap = b;
      bstart = 1'b1;
      @(posedge clk_i);
      #1;
      bstart = 1'b0;
   endtask : blk
   task automatic t_side();
      cact = 1'b1;
      stereo = 1'b1;
      remat = 4'ha;
      blk(3'h0, 1'b0, 8'h00, 4'h0);
      check(cmiss, 1'b1);
      check(remat_o, 4'ha);
      check(mbits, 5'h00);
      blk(3'h3, 1'b1, 8'h5c, 4'h0);
      check(coord_o, 8'h5c);
      blk(3'h4, 1'b0, 8'h11, 4'h0);
      check(coord_o, 8'h5c);
      check(cmiss, 1'b0);
      for (int i = 1; i < 16; i++) begin
         blk(3'h5, 1'b0, 8'h00, i[3:0]);
         check(mbits, i + 1);
      end
      stereo = 1'b0;
      cact = 1'b0;
      remat = 4'h5;
      blk(3'h0, 1'b0, 8'h33, 4'h0);
      check(remat_o, 4'ha);
      check(cmiss, 1'b0);
   endtask : t_side
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      results();
   end
   initial begin
      {arst_n_i, bidx, bstart, cact, cval, ccoord, stereo, remat, bap} = '0;
      good = dmx.frame(SYNC_WORD, {FS_48K, 6'h2a}, 24'h5a3c96);
      repeat (3) @(posedge clk_i);
      #1;
      check(gain, 16'h0000);
      arst_n_i = 1'b1;
      t_side();
      t_lock();
      t_b2b();
      t_crc_err();
      t_loss();
      results();
   end
endmodule : asfr_receiver_bench
